/* rtl/ppic_parallel_interface_core.sv */
// Functional notes
// - Ports one, two, three and control sit at offsets zero to three.
// - Control register is write-only; reading its address never returns it.
// - A mode write clears all output latches and handshake flags.
// - Bit set/reset changes one selected third-port bit only.
// - Interrupt masks clear at reset and on every mode write.
// - Masks gate both group interrupts, produced only in modes 1 and 2.
// - Strobed input on port one takes third-port bits 3, 4, 5.
// - Group one interrupt drives third-port bit 3 in that configuration.
// - Control value a1 gives strobed input, basic output, mixed third port.
// - Third-port bits 0, 1, 2, 6, 7 stay plain I/O meanwhile.
// - Control writes carry either a mode definition or a bit command.
// - Group one: port one plus upper nibble; group two: port two, lower.
// - Each group decodes control words and configures its own ports.
// - Port one has an output latch and a separate input latch.
// - Port two has an in/out latch plus an input buffer.
// - Third port latches outputs but reads inputs unlatched.
// - Third port splits into two nibbles for control and status.
// - Under reset all 24 lines are inputs, undriven.
// - Input-full sets while strobe low, clears on read's rising edge.
// - Only the lowest four of the 16 decoded addresses reach registers.
`timescale 1ns/1ps
module ppic_parallel_interface_core (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Host bus
    input  wire logic       host_cs_n,
    input  wire logic       host_rd_n,
    input  wire logic       host_wr_n,
    input  wire logic [3:0] host_addr,
    input  wire logic [7:0] host_d_in,
    output logic      [7:0] host_d_out,
    output logic            host_d_oe,
    // First port
    input  wire logic [7:0] pa_in,
    output logic      [7:0] pa_out,
    output logic      [7:0] pa_oe,
    // Second port
    input  wire logic [7:0] pb_in,
    output logic      [7:0] pb_out,
    output logic      [7:0] pb_oe,
    // Third port
    input  wire logic [7:0] pc_in,
    output logic      [7:0] pc_out,
    output logic      [7:0] pc_oe,
    // Group interrupts
    output logic            group_one_irq,
    output logic            group_two_irq
);
    import ppic_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ppic_host_t h1;
        ppic_host_t h2;
        ppic_pins_t p1;
        ppic_pins_t p2;
        logic       rd_prev;
        logic       wr_prev;
        logic       w_hit;
        logic [1:0] w_addr;
        logic [7:0] w_data;
        logic       r_hit;
        logic [1:0] r_addr;
        ppic_cfg_t  cfg;
        logic [7:0] pa_q;
        logic [7:0] pb_q;
        logic [7:0] pc_q;
        logic [7:0] pa_lat;
        logic [7:0] pb_lat;
        logic       irq_enable_mask_ai;
        logic       irq_enable_mask_ao;
        logic       irq_enable_mask_b;
        logic [7:0] d_out;
        logic       d_oe;
        logic [7:0] pa_oe;
        logic [7:0] pb_oe;
        logic [7:0] pc_o;
        logic [7:0] pc_oe;
        logic       irq1;
        logic       irq2;
    } ppic_core_state_t;

    // Host lines idle high so the synchronisers show no false strobe at release
    localparam ppic_core_state_t ST_RST = '{
        h1:      '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0},
        h2:      '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0},
        rd_prev: 1'b1,
        wr_prev: 1'b1,
        cfg:     ppic_cfg_t'(CFG_RST),
        pa_q:    DATA_RST,
        pb_q:    DATA_RST,
        pc_q:    DATA_RST,
        default: '0
    };

    ppic_core_state_t s;
    ppic_core_state_t n;
    ppic_host_t       host_now;
    ppic_pins_t       pins_now;
    ppic_hs_in_t      ev_ai;
    ppic_hs_in_t      ev_ao;
    ppic_hs_in_t      ev_b;
    ppic_hs_out_t     st_ai;
    ppic_hs_out_t     st_ao;
    ppic_hs_out_t     st_b;
    logic             win_hit;
    logic             rd_fall;
    logic             rd_rise;
    logic             wr_fall;
    logic             wr_rise;
    logic             a_strobed;
    logic             a_bidir;
    logic             a_in_en;
    logic             a_out_en;
    logic             mode_wr;
    logic             irq1_v;
    logic             irq2_v;
    logic [2:0]       bsr_sel;
    logic [7:0]       pa_rd_v;
    logic [7:0]       pb_rd_v;
    logic [7:0]       pc_rd_v;
    logic [7:0]       pc_o_v;
    logic [7:0]       pc_oe_v;

    function automatic logic at(input logic [1:0] a, input logic [1:0] ofs);
        return a == ofs;
    endfunction : at
    assign host_now = {host_cs_n, host_rd_n, host_wr_n, host_addr, host_d_in};
    assign pins_now = {pa_in, pb_in, pc_in};

    // ************************************************************
    // Host strobe edges
    // ************************************************************
    // Offsets four to fifteen are selected by the board but answer nothing
    assign win_hit = ~s.h2.cs_n & (s.h2.addr[3:2] == ADDR_WIN_HI);
    assign rd_fall = s.rd_prev & ~s.h2.rd_n & win_hit;
    assign rd_rise = ~s.rd_prev & s.h2.rd_n & s.r_hit;
    assign wr_fall = s.wr_prev & ~s.h2.wr_n & win_hit;
    assign wr_rise = ~s.wr_prev & s.h2.wr_n & s.w_hit;

    // ************************************************************
    // Group modes
    // ************************************************************
    assign a_strobed = s.cfg.ma != 2'h0;
    assign a_bidir   = s.cfg.ma[1];
    assign a_in_en   = a_strobed & (s.cfg.a_in | a_bidir);
    assign a_out_en  = a_strobed & (~s.cfg.a_in | a_bidir);
    assign mode_wr   = wr_rise & at(s.w_addr, OFS_CTRL) & s.w_data[CW_MODE_FLAG];
    assign bsr_sel   = s.w_data[BSR_SEL_LSB +: 3];

    // ************************************************************
    // Handshake channels
    // ************************************************************
    assign ev_ai = '{
        enable:     a_in_en,
        is_input:   1'b1,
        clear:      mode_wr,
        strobe_lo:  ~s.p2.pc[PC_STB_A],
        host_start: rd_fall & at(s.h2.addr[1:0], OFS_PORT_A),
        host_end:   rd_rise & at(s.r_addr, OFS_PORT_A)
    };
    assign ev_ao = '{
        enable:     a_out_en,
        is_input:   1'b0,
        clear:      mode_wr,
        strobe_lo:  ~s.p2.pc[PC_ACK_A],
        host_start: wr_fall & at(s.h2.addr[1:0], OFS_PORT_A),
        host_end:   wr_rise & at(s.w_addr, OFS_PORT_A)
    };
    assign ev_b = '{
        enable:     s.cfg.mb,
        is_input:   s.cfg.b_in,
        clear:      mode_wr,
        strobe_lo:  ~s.p2.pc[PC_STB_B],
        host_start: (s.cfg.b_in ? rd_fall : wr_fall) & at(s.h2.addr[1:0], OFS_PORT_B),
        host_end:   s.cfg.b_in ? (rd_rise & at(s.r_addr, OFS_PORT_B))
                               : (wr_rise & at(s.w_addr, OFS_PORT_B))
    };

    ppic_hs_channel u_hs_a_in (
        .clock (clock),
        .rst   (rst),
        .ev    (ev_ai),
        .st    (st_ai)
    );

    ppic_hs_channel u_hs_a_out (
        .clock (clock),
        .rst   (rst),
        .ev    (ev_ao),
        .st    (st_ao)
    );

    ppic_hs_channel u_hs_b (
        .clock (clock),
        .rst   (rst),
        .ev    (ev_b),
        .st    (st_b)
    );

    // Requests only ever leave the device through an armed mask
    assign irq1_v = (st_ai.pend & s.irq_enable_mask_ai) | (st_ao.pend & s.irq_enable_mask_ao);
    assign irq2_v = st_b.pend & s.irq_enable_mask_b;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = s;

        // Two-stage synchronisers for every pin
        n.h1 = host_now;
        n.h2 = s.h1;
        n.p1 = pins_now;
        n.p2 = s.p1;
        n.rd_prev = s.h2.rd_n;
        n.wr_prev = s.h2.wr_n;

        // Read values per port
        if (a_in_en) begin
            pa_rd_v = s.pa_lat;
        end else if (s.cfg.a_in) begin
            pa_rd_v = s.p2.pa;
        end else begin
            pa_rd_v = s.pa_q;
        end
        if (~s.cfg.b_in) begin
            pb_rd_v = s.pb_q;
        end else if (s.cfg.mb) begin
            pb_rd_v = s.pb_lat;
        end else begin
            pb_rd_v = s.p2.pb;
        end

        // Third port: nibble directions first, handshake lines override
        pc_o_v  = s.pc_q;
        pc_oe_v = {{4{~s.cfg.cu_in}}, {4{~s.cfg.cl_in}}};
        pc_rd_v = (s.pc_q & pc_oe_v) | (s.p2.pc & ~pc_oe_v);
        if (s.cfg.mb) begin
            pc_o_v[PC_IRQ_B]  = irq2_v;
            pc_oe_v[PC_IRQ_B] = 1'b1;
            pc_rd_v[PC_IRQ_B] = irq2_v;
            pc_o_v[PC_FLAG_B]  = s.cfg.b_in ? st_b.full : ~st_b.full;
            pc_oe_v[PC_FLAG_B] = 1'b1;
            pc_rd_v[PC_FLAG_B] = pc_o_v[PC_FLAG_B];
            pc_oe_v[PC_STB_B] = 1'b0;
            pc_rd_v[PC_STB_B] = s.irq_enable_mask_b;
        end
        if (a_strobed) begin
            pc_o_v[PC_IRQ_A]  = irq1_v;
            pc_oe_v[PC_IRQ_A] = 1'b1;
            pc_rd_v[PC_IRQ_A] = irq1_v;
        end
        // Bits outside the borrowed set keep their nibble direction
        if (a_in_en) begin
            pc_oe_v[PC_STB_A] = 1'b0;
            pc_rd_v[PC_STB_A] = s.irq_enable_mask_ai;
            pc_o_v[PC_IBF_A]  = st_ai.full;
            pc_oe_v[PC_IBF_A] = 1'b1;
            pc_rd_v[PC_IBF_A] = st_ai.full;
        end
        if (a_out_en) begin
            pc_o_v[PC_OBF_A]  = ~st_ao.full;
            pc_oe_v[PC_OBF_A] = 1'b1;
            pc_rd_v[PC_OBF_A] = ~st_ao.full;
            pc_oe_v[PC_ACK_A] = 1'b0;
            pc_rd_v[PC_ACK_A] = s.irq_enable_mask_ao;
        end

        // Input latches follow the pins while their strobe is low
        if (a_in_en & ~s.p2.pc[PC_STB_A]) begin
            n.pa_lat = s.p2.pa;
        end
        if (s.cfg.mb & s.cfg.b_in & ~s.p2.pc[PC_STB_B]) begin
            n.pb_lat = s.p2.pb;
        end

        // Write capture: address and data resampled every cycle the strobe is low
        if (~s.h2.wr_n & win_hit) begin
            n.w_hit  = 1'b1;
            n.w_addr = s.h2.addr[1:0];
            n.w_data = s.h2.data;
        end
        if (wr_rise) begin
            n.w_hit = 1'b0;
            if (at(s.w_addr, OFS_PORT_A)) begin
                n.pa_q = s.w_data;
            end else if (at(s.w_addr, OFS_PORT_B)) begin
                n.pb_q = s.w_data;
            end else if (at(s.w_addr, OFS_PORT_C)) begin
                n.pc_q = s.w_data;
            end else if (s.w_data[CW_MODE_FLAG]) begin
                n.cfg     = ppic_cfg_t'(s.w_data[6:0]);
                n.cfg.a_in = n.cfg.a_in ^ (n.cfg.ma == 2'h1);
                n.pa_q    = DATA_RST;
                n.pb_q    = DATA_RST;
                n.pc_q    = DATA_RST;
                n.irq_enable_mask_ai = 1'b0;
                n.irq_enable_mask_ao = 1'b0;
                n.irq_enable_mask_b  = 1'b0;
            end else begin
                n.pc_q[bsr_sel] = s.w_data[BSR_VALUE];
                // Mask bits ride on the strobe and acknowledge positions
                if (a_strobed & (bsr_sel == PC_STB_A)) begin
                    n.irq_enable_mask_ai = s.w_data[BSR_VALUE];
                end
                if (a_strobed & (bsr_sel == PC_ACK_A)) begin
                    n.irq_enable_mask_ao = s.w_data[BSR_VALUE];
                end
                if (s.cfg.mb & (bsr_sel == PC_STB_B)) begin
                    n.irq_enable_mask_b = s.w_data[BSR_VALUE];
                end
            end
        end

        // Read cycle: data is refreshed every cycle the strobe stays low
        if (rd_fall) begin
            n.r_hit  = 1'b1;
            n.r_addr = s.h2.addr[1:0];
        end else if (rd_rise) begin
            n.r_hit = 1'b0;
        end
        n.d_oe = n.r_hit;
        if (at(n.r_addr, OFS_PORT_A)) begin
            n.d_out = pa_rd_v;
        end else if (at(n.r_addr, OFS_PORT_B)) begin
            n.d_out = pb_rd_v;
        end else if (at(n.r_addr, OFS_PORT_C)) begin
            n.d_out = pc_rd_v;
        end else begin
            n.d_out = CTRL_READ_VAL;
        end

        // Pin drivers
        n.pa_oe = a_bidir ? {8{~s.p2.pc[PC_ACK_A]}} : {8{~s.cfg.a_in}};
        n.pb_oe = {8{~s.cfg.b_in}};
        n.pc_o  = pc_o_v;
        n.pc_oe = pc_oe_v;
        n.irq1  = irq1_v;
        n.irq2  = irq2_v;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign host_d_out    = s.d_out;
    assign host_d_oe     = s.d_oe;
    assign pa_out        = s.pa_q;
    assign pa_oe         = s.pa_oe;
    assign pb_out        = s.pb_q;
    assign pb_oe         = s.pb_oe;
    assign pc_out        = s.pc_o;
    assign pc_oe         = s.pc_oe;
    assign group_one_irq = s.irq1;
    assign group_two_irq = s.irq2;

endmodule : ppic_parallel_interface_core

/* rtl/ppic_pkg.sv */
package ppic_pkg;

    // ************************************************************
    // Register offsets and address window
    // ************************************************************
    localparam logic [1:0] OFS_PORT_A  = 2'h0;
    localparam logic [1:0] OFS_PORT_B  = 2'h1;
    localparam logic [1:0] OFS_PORT_C  = 2'h2;
    localparam logic [1:0] OFS_CTRL    = 2'h3;
    localparam logic [1:0] ADDR_WIN_HI = 2'h0;

    // ************************************************************
    // Control word fields
    // ************************************************************
    localparam int         CW_MODE_FLAG = 7;
    localparam int         BSR_SEL_LSB  = 1;
    localparam int         BSR_VALUE    = 0;

    // ************************************************************
    // Third port handshake bit positions
    // ************************************************************
    localparam logic [2:0] PC_IRQ_B  = 3'h0;
    localparam logic [2:0] PC_FLAG_B = 3'h1;
    localparam logic [2:0] PC_STB_B  = 3'h2;
    localparam logic [2:0] PC_IRQ_A  = 3'h3;
    localparam logic [2:0] PC_STB_A  = 3'h4;
    localparam logic [2:0] PC_IBF_A  = 3'h5;
    localparam logic [2:0] PC_ACK_A  = 3'h6;
    localparam logic [2:0] PC_OBF_A  = 3'h7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [6:0] CFG_RST       = 7'h1b;
    localparam logic [7:0] DATA_RST      = 8'h00;
    localparam logic [7:0] CTRL_READ_VAL = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] ma;
        logic       a_in;
        logic       cu_in;
        logic       mb;
        logic       b_in;
        logic       cl_in;
    } ppic_cfg_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] addr;
        logic [7:0] data;
    } ppic_host_t;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
    } ppic_pins_t;

    typedef struct packed {
        logic enable;
        logic is_input;
        logic clear;
        logic strobe_lo;
        logic host_start;
        logic host_end;
    } ppic_hs_in_t;

    typedef struct packed {
        logic full;
        logic pend;
    } ppic_hs_out_t;

    typedef struct packed {
        logic full;
        logic pend;
        logic strobe_prev;
    } ppic_hs_state_t;

endpackage : ppic_pkg

/* rtl/ppic_hs_channel.sv */
`timescale 1ns/1ps
module ppic_hs_channel (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst,
    // Events and flags
    input  ppic_pkg::ppic_hs_in_t  ev,
    output ppic_pkg::ppic_hs_out_t st
);
    import ppic_pkg::*;

    ppic_hs_state_t s;
    ppic_hs_state_t n;
    logic           fset;
    logic           fclr;
    logic           pset;

    always_comb begin
        n      = s;
        // Input: strobe fills, read end empties; output: write end fills, ack empties
        fset   = ev.is_input ? ev.strobe_lo : ev.host_end;
        fclr   = ev.is_input ? ev.host_end : ev.strobe_lo;
        // Request rises with the strobe's trailing edge once the transfer completed
        pset   = s.strobe_prev & ~ev.strobe_lo & (s.full == ev.is_input);
        n.full = fset | (s.full & ~fclr);
        n.pend = pset | (s.pend & ~ev.host_start);
        n.strobe_prev = ev.strobe_lo;
        if (~ev.enable | ev.clear) begin
            n = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign st = '{full: s.full, pend: s.pend};

endmodule : ppic_hs_channel

/* dv/ppic_properties.sv */
`timescale 1ns/1ps
module ppic_properties (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Host bus
    input wire logic       host_cs_n,
    input wire logic       host_rd_n,
    input wire logic       host_wr_n,
    input wire logic [3:0] host_addr,
    input wire logic [7:0] host_d_in,
    input wire logic [7:0] host_d_out,
    input wire logic       host_d_oe,
    // Port pins
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe,
    // Interrupts
    input wire logic       group_one_irq,
    input wire logic       group_two_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    reset_inputs_a: assert property ($fell(rst) |->
        pa_oe == 8'h00 && pb_oe == 8'h00 && pc_oe == 8'h00 && !host_d_oe)
        else $error("Pins driven right after reset");
    ctrl_read_zero_a: assert property (
        (!host_cs_n && !host_rd_n && host_addr == 4'h3) [*6] |-> host_d_out == 8'h00)
        else $error("Control read returned data");
    window_refuse_a: assert property (
        (!host_cs_n && !host_rd_n && host_addr[3:2] != 2'h0) [*6] |-> !host_d_oe)
        else $error("Bus driven outside the register window");
    deselect_quiet_a: assert property (host_cs_n [*8] |-> !host_d_oe)
        else $error("Bus driven while not selected");
    mode_clear_a: assert property (
        $rose(host_wr_n) && !host_cs_n && host_addr == 4'h3 && host_d_in[7]
        |-> ##[2:7] (pa_out == 8'h00 && pb_out == 8'h00))
        else $error("Output latches kept after mode write");
    mask_clear_a: assert property (
        $rose(host_wr_n) && !host_cs_n && host_addr == 4'h3 && host_d_in[7]
        |-> ##8 !(group_one_irq || group_two_irq))
        else $error("Interrupt survived mode write");
    irq_on_pin_a: assert property (
        $rose(group_one_irq) |-> ##[0:2] (pc_out[3] && pc_oe[3]))
        else $error("Group one request missing on third port bit 3");
    full_on_load_a: assert property (
        $fell(pc_in[4]) && !pc_oe[4] && pc_oe[5] |-> ##[1:5] pc_out[5])
        else $error("Input full flag not set by load strobe");
endmodule : ppic_properties

bind ppic_parallel_interface_core ppic_properties chk_i (.clock, .rst, .host_cs_n,
    .host_rd_n, .host_wr_n, .host_addr, .host_d_in, .host_d_out, .host_d_oe, .pa_out,
    .pa_oe, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .group_one_irq, .group_two_irq);

/* dv/ppic_peripheral.sv */
`timescale 1ns/1ps
module ppic_peripheral (
    // Clock
    input  wire logic       clock,
    // Device side of the pins
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pc_out,
    input  wire logic [7:0] pc_oe,
    // Resolved pin levels
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in,
    output logic      [7:0] pc_in
);
    logic [7:0] pa_drv = 8'h5a;
    logic [7:0] pb_drv = 8'hc3;
    logic [7:0] pc_drv = 8'hff;

    // Device wins on each bit it drives
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_drv);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_drv);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_drv);

    task automatic load_a(input logic [7:0] d, input int hold);
        @(posedge clock);
        #1 pa_drv = d;
        pc_drv[4] = 1'b0;
        repeat (hold) @(posedge clock);
        #1 pc_drv[4] = 1'b1;
        repeat (3) @(posedge clock);
        // Hold time over: data changes so a missing latch shows up
        #1 pa_drv = ~d;
    endtask : load_a

    task automatic load_b(input logic [7:0] d, input int hold);
        @(posedge clock);
        #1 pb_drv = d;
        pc_drv[2] = 1'b0;
        repeat (hold) @(posedge clock);
        #1 pc_drv[2] = 1'b1;
        repeat (3) @(posedge clock);
        #1 pb_drv = ~d;
    endtask : load_b
endmodule : ppic_peripheral

/* dv/parallel_io_port_controller_test.sv */
`timescale 1ns/1ps
module parallel_io_port_controller_test;
    import ppic_pkg::*;

    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       host_cs_n = 1'b1;
    logic       host_rd_n = 1'b1;
    logic       host_wr_n = 1'b1;
    logic [3:0] host_addr = 4'h0;
    logic [7:0] host_d_in = 8'h00;
    logic [7:0] host_d_out, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic [7:0] pc_in, pc_out, pc_oe, rdata;
    logic       host_d_oe, group_one_irq, group_two_irq, roe;
    int         mismatches = 0;
    int         n_compared = 0;

    ppic_parallel_interface_core dut (.clock, .rst, .host_cs_n, .host_rd_n, .host_wr_n,
        .host_addr, .host_d_in, .host_d_out, .host_d_oe, .pa_in, .pa_out, .pa_oe, .pb_in,
        .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .group_one_irq, .group_two_irq);
    ppic_peripheral per (.clock, .pa_out, .pa_oe, .pb_out, .pb_oe, .pc_out, .pc_oe,
        .pa_in, .pb_in, .pc_in);

    initial forever #4 clock = ~clock;

    // ********************************
    // Bus cycles and checks
    // ********************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic sel);
        @(posedge clock);
        #1 host_cs_n = ~sel;
        host_addr = a;
        host_d_in = d;
        host_wr_n = 1'b0;
        repeat (4) @(posedge clock);
        #1 host_wr_n = 1'b1;
        @(posedge clock);
        #1 host_cs_n = 1'b1;
        repeat (7) @(posedge clock);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        #1 host_cs_n = 1'b0;
        host_addr = a;
        host_rd_n = 1'b0;
        repeat (8) @(posedge clock);
        #1 rdata = host_d_out;
        roe = host_d_oe;
        host_rd_n = 1'b1;
        @(posedge clock);
        #1 host_cs_n = 1'b1;
        repeat (6) @(posedge clock);
    endtask : rd

    task automatic end_sim;
        $display("Checks: %0d, mismatches: %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        chk(pa_oe | pb_oe | pc_oe, 8'h00);
        chk({6'h0, group_one_irq, group_two_irq}, 8'h00);
    endtask : t_reset

    task automatic t_basic;
        wr(4'h3, 8'h80, 1'b1);
        wr({2'h0, OFS_PORT_A}, 8'ha5, 1'b1);
        wr({2'h0, OFS_PORT_B}, 8'h3c, 1'b1);
        wr({2'h0, OFS_PORT_C}, 8'h96, 1'b1);
        wr({2'h0, OFS_PORT_A}, 8'h11, 1'b0);
        chk(pa_out, 8'ha5);
        chk(pb_out, 8'h3c);
        chk(pc_oe & pc_out, 8'h96);
        rd({2'h0, OFS_CTRL});
        chk(rdata, CTRL_READ_VAL);
        rd(4'h5);
        chk({7'h0, roe}, 8'h00);
        wr(4'h3, 8'h07, 1'b1);
        wr(4'h3, 8'h0e, 1'b1);
        chk(pc_out, 8'h1e);
        chk(pa_out, 8'ha5);
    endtask : t_basic

    task automatic t_groups;
        wr(4'h3, 8'h88, 1'b1);
        chk(pa_out | pb_out, 8'h00);
        chk(pc_oe, 8'h0f);
        chk(pa_oe & pb_oe, 8'hff);
        wr(4'h3, 8'h93, 1'b1);
        chk(pc_oe, 8'hf0);
        rd({2'h0, OFS_PORT_B});
        chk(rdata, 8'hc3);
    endtask : t_groups

    task automatic t_strobed;
        wr(4'h3, 8'ha1, 1'b1);
        chk(pa_oe, 8'h00);
        chk(pb_oe, 8'hff);
        chk(pc_oe, 8'he8);
        wr(4'h3, 8'h0f, 1'b1);
        chk(pc_out & 8'hc0, 8'h80);
        per.load_a(8'h3c, 4);
        repeat (4) @(posedge clock);
        chk(pc_out & 8'h28, 8'h20);
        wr(4'h3, 8'h09, 1'b1);
        chk({6'h0, group_one_irq, group_two_irq}, 8'h02);
        chk(pc_out & 8'h08, 8'h08);
        rd({2'h0, OFS_PORT_A});
        chk(rdata, 8'h3c);
        chk({pc_out[5], pc_out[3], 6'h0}, 8'h00);
        per.load_a(8'hc5, 1);
        repeat (4) @(posedge clock);
        chk({7'h0, group_one_irq}, 8'h01);
        wr(4'h3, 8'ha1, 1'b1);
        chk({6'h0, group_one_irq, pc_out[5]}, 8'h00);
    endtask : t_strobed

    task automatic t_group_two;
        wr(4'h3, 8'h86, 1'b1);
        chk(pc_oe, 8'hfb);
        wr(4'h3, 8'h05, 1'b1);
        per.load_b(8'h69, 2);
        repeat (4) @(posedge clock);
        chk({6'h0, group_one_irq, group_two_irq}, 8'h01);
        chk(pc_out & 8'h03, 8'h03);
        rd({2'h0, OFS_PORT_B});
        chk(rdata, 8'h69);
        chk({group_two_irq, pc_out[1], 6'h0}, 8'h00);
    endtask : t_group_two

    initial begin
        repeat (6) @(posedge clock);
        t_reset();
        #1 rst = 1'b0;
        t_basic();
        t_groups();
        t_strobed();
        t_group_two();
        end_sim();
    end

    // Roughly twenty times the expected run length
    initial begin
        #50000;
        mismatches++;
        end_sim();
    end
endmodule : parallel_io_port_controller_test
